//--- hdl/ingress_acl_filter.sv
// Purpose: per-port ingress access list engine with 802.1X gating
// Assumes: parsed header fields arrive on the same clock with a pulse
// Notes: result appears one cycle after frame_valid_i
//
// Behaviour
// - EAPOL when destination is 01-80-C2-00-00-03 or reserved base -00-03.
// - EAPOL frames always go to the host port.
// - Unauthorized port admits no user frames into the fabric.
// - Each port owns its own separately programmed list.
// - Sixteen entries per port: matching, action and processing.
// - Watchdog mode interrupts when no matching frame arrives in time.
// - Event mode interrupts after the programmed number of frames.
// - Count-enabled rule takes 11-bit value from action, no forwarding.
// - Outside count mode, same-index rules are independent.
// - Count rule uses same-index action rule as counter storage.
// - Processing entry ANDs all selected matching results.
// - Several entries naming one action act as OR.
// - At most one action; lowest action pointer wins.
// - Processing entry holds a 4-bit action pointer.
// - Processing entry holds a 16-bit rule select mask.
// - Layer 01 options: count, EtherType, MAC, both.
// - Layer 10 options: masked IPv4, unmasked pair, others reserved.
// - Layer 11 options: protocol, TCP port, UDP port, sequence.
// - Layer 00 rule is disabled and never true.
// - Time-unit bit: 0 microseconds, 1 milliseconds.
// - Algorithm bit 1 counts frames; 0 times out per unit.
// - Equality bit: 1 true on equal, 0 true on unequal.
//
// Local design decisions: the register addresses and the strobed register port.
`include "acl_filter_map.svh"
`default_nettype none
module ingress_acl_filter
  import acl_filter_pkg::*;
#(
  parameter int NUM_PORTS = 7
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  input wire logic frame_valid_i,
  input wire logic [2:0] frame_port_i,
  input wire logic [47:0] dst_mac_i,
  input wire logic [47:0] src_mac_i,
  input wire logic [15:0] ether_type_i,
  input wire logic is_ipv4_i,
  input wire logic is_tcp_i,
  input wire logic is_udp_i,
  input wire logic [31:0] ip_src_i,
  input wire logic [31:0] ip_dst_i,
  input wire logic [7:0] ip_proto_i,
  input wire logic [15:0] l4_src_i,
  input wire logic [15:0] l4_dst_i,
  input wire logic [31:0] tcp_seq_i,
  output logic result_valid_o,
  output logic eapol_o,
  output logic to_host_o,
  output logic admit_o,
  output logic action_hit_o,
  output logic [3:0] action_ptr_o,
  output logic [31:0] action_word_o,
  output logic irq_o
);
  localparam int NE = NUM_PORTS * 16;

  // ------------------------------------------------------------------
  // tables, one set per port
  // ------------------------------------------------------------------
  logic [5:0] rule_ctrl_reg [NE];
  logic [31:0] rule_d0_reg [NE];
  logic [31:0] rule_d1_reg [NE];
  logic [31:0] action_reg [NE];
  match_rule_select_mask_t sel_mask_reg [NE];
  action_rule_pointer_t ptr_reg [NE];
  logic [10:0] cnt_reg [NE];
  logic [10:0] cnt_next [NE];
  logic [NE-1:0] flags_reg;
  logic [NE-1:0] flags_next;
  logic [NE-1:0] fire;
  logic [NE-1:0] clr;
  logic [NUM_PORTS-1:0] auth_reg;
  logic [31:0] rsv_mcast_reg;
  logic [7:0] us_cnt_reg;
  logic [9:0] ms_cnt_reg;
  logic us_tick_reg;
  logic ms_tick_reg;

  function automatic int unsigned idx(input logic [2:0] p,
                                      input logic [3:0] e);
    return 32'(p) * 16 + 32'(e);
  endfunction

  // raw comparison of one matching rule against the current frame
  function automatic logic rule_hit(input logic [5:0] c,
                                    input logic [31:0] d0,
                                    input logic [31:0] d1);
    logic [47:0] mac;
    logic [31:0] ip;
    logic [15:0] l4;
    logic cmp;
    logic ok;
    mac = c[`ACL_CTRL_SRC_SEL] ? src_mac_i : dst_mac_i;
    ip = c[`ACL_CTRL_SRC_SEL] ? ip_src_i : ip_dst_i;
    l4 = c[`ACL_CTRL_SRC_SEL] ? l4_src_i : l4_dst_i;
    ok = 1'b1;
    cmp = 1'b0;
    case (match_layer_select_t'(c[1:0]))
      LAYER_L2: begin
        case (c[3:2])
          2'h1: cmp = ether_type_i == d1[31:16];
          2'h2: cmp = mac == {d1[15:0], d0};
          default: cmp = mac == {d1[15:0], d0} &&
                         ether_type_i == d1[31:16];
        endcase
      end
      LAYER_L3: begin
        ok = is_ipv4_i;
        case (c[3:2])
          2'h1: cmp = ((ip ^ d0) & ~d1) == 32'h0000_0000;
          2'h2: cmp = ip_src_i == d0 && ip_dst_i == d1;
          default: ok = 1'b0;
        endcase
      end
      LAYER_L4: begin
        ok = is_ipv4_i;
        case (c[3:2])
          2'h0: cmp = ip_proto_i == d0[7:0];
          2'h1: begin
            ok = ok && is_tcp_i;
            cmp = l4 == d0[15:0];
          end
          2'h2: begin
            ok = ok && is_udp_i;
            cmp = l4 == d0[15:0];
          end
          default: begin
            ok = ok && is_tcp_i;
            cmp = tcp_seq_i == d0;
          end
        endcase
      end
      default: ok = 1'b0;
    endcase
    return ok && (cmp == c[`ACL_CTRL_EQ]);
  endfunction

  // ------------------------------------------------------------------
  // per-frame evaluation
  // ------------------------------------------------------------------
  logic [15:0] hit_vec;
  logic [15:0] cnt_mode_vec;
  logic [15:0] dis_vec;
  logic [15:0] match_vec;
  logic [15:0] act_vec;
  logic [3:0] first_act;
  logic eapol;
  logic port_ok;

  assign port_ok = 32'(frame_port_i) < NUM_PORTS;
  assign eapol = dst_mac_i == `ACL_EAPOL_DA ||
                 dst_mac_i == {rsv_mcast_reg, `ACL_EAPOL_OFS};

  always_comb begin
    int unsigned k;
    k = 0;
    hit_vec = 16'h0000;
    cnt_mode_vec = 16'h0000;
    dis_vec = 16'h0000;
    act_vec = 16'h0000;
    first_act = 4'h0;
    for (int e = 0; e < 16; e++) begin
      k = idx(frame_port_i, 4'(e));
      if (port_ok) begin
        hit_vec[e] = rule_hit(rule_ctrl_reg[k], rule_d0_reg[k],
                              rule_d1_reg[k]);
        cnt_mode_vec[e] = rule_ctrl_reg[k][3:0] == 4'h1;
        dis_vec[e] = rule_ctrl_reg[k][1:0] == 2'h0;
      end
    end
    // count rules never feed forwarding
    match_vec = hit_vec & ~cnt_mode_vec;
    for (int e = 0; e < 16; e++) begin
      k = idx(frame_port_i, 4'(e));
      if (port_ok && sel_mask_reg[k] != 16'h0000 &&
          (match_vec & sel_mask_reg[k]) == sel_mask_reg[k]) begin
        act_vec[ptr_reg[k]] = 1'b1;
      end
    end
    for (int a = 15; a >= 0; a--) begin
      if (act_vec[a]) begin
        first_act = 4'(a);
      end
    end
  end

  // ------------------------------------------------------------------
  // time base for the watchdog
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      us_cnt_reg <= 8'h00;
      ms_cnt_reg <= 10'h000;
      us_tick_reg <= 1'b0;
      ms_tick_reg <= 1'b0;
    end else begin
      us_tick_reg <= us_cnt_reg == 8'(`ACL_US_CYCLES - 1);
      ms_tick_reg <= us_tick_reg && ms_cnt_reg == 10'(`ACL_MS_US - 1);
      if (us_cnt_reg == 8'(`ACL_US_CYCLES - 1)) begin
        us_cnt_reg <= 8'h00;
      end else begin
        us_cnt_reg <= us_cnt_reg + 8'h01;
      end
      if (us_tick_reg) begin
        if (ms_cnt_reg == 10'(`ACL_MS_US - 1)) begin
          ms_cnt_reg <= 10'h000;
        end else begin
          ms_cnt_reg <= ms_cnt_reg + 10'h001;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // counters; both algorithms count up toward the stored value
  // ------------------------------------------------------------------
  always_comb begin
    logic hit;
    logic tick;
    logic [10:0] val;
    logic [10:0] inc;
    hit = 1'b0;
    tick = 1'b0;
    val = 11'h000;
    inc = 11'h000;
    for (int k = 0; k < NE; k++) begin
      hit = frame_valid_i && idx(frame_port_i, 4'h0) == 32'(k & ~15) &&
            hit_vec[k % 16];
      tick = action_reg[k][`ACL_ACT_TU] ? ms_tick_reg : us_tick_reg;
      val = action_reg[k][10:0];
      inc = cnt_reg[k] + 11'h001;
      cnt_next[k] = 11'h000;
      fire[k] = 1'b0;
      if (rule_ctrl_reg[k][3:0] == 4'h1 && val != 11'h000) begin
        if (action_reg[k][`ACL_ACT_CA]) begin
          cnt_next[k] = cnt_reg[k];
          if (hit) begin
            fire[k] = inc == val;
            cnt_next[k] = (inc == val) ? 11'h000 : inc;
          end
        end else if (!hit) begin
          cnt_next[k] = cnt_reg[k];
          if (tick) begin
            fire[k] = inc >= val;
            cnt_next[k] = (inc >= val) ? 11'h000 : inc;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int k = 0; k < NE; k++) begin
        cnt_reg[k] <= 11'h000;
      end
    end else begin
      for (int k = 0; k < NE; k++) begin
        cnt_reg[k] <= cnt_next[k];
      end
    end
  end

  // ------------------------------------------------------------------
  // sticky flags, write one to clear; a new event beats the clear
  // ------------------------------------------------------------------
  always_comb begin
    clr = '0;
    if (we_i && addr_i[`ACL_GLOBAL_BIT] &&
        addr_i[3:0] == `ACL_G_FLAGS) begin
      for (int k = 0; k < NE; k++) begin
        if (32'(k / 16) == 32'(addr_i[`ACL_PORT_HI:`ACL_PORT_LO])) begin
          clr[k] = wdata_i[k % 16];
        end
      end
    end
    flags_next = fire | (flags_reg & ~clr);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      irq_o <= |flags_next;
    end
  end

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  logic [2:0] wp;
  logic [3:0] we_ent;
  int unsigned wk;
  assign wp = addr_i[`ACL_PORT_HI:`ACL_PORT_LO];
  assign we_ent = addr_i[`ACL_ENTRY_HI:`ACL_ENTRY_LO];
  assign wk = idx(wp, we_ent);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      auth_reg <= '0;
      rsv_mcast_reg <= `ACL_RSV_MCAST_RST;
      for (int k = 0; k < NE; k++) begin
        rule_ctrl_reg[k] <= 6'h00;
        rule_d0_reg[k] <= 32'h0000_0000;
        rule_d1_reg[k] <= 32'h0000_0000;
        action_reg[k] <= 32'h0000_0000;
        sel_mask_reg[k] <= 16'h0000;
        ptr_reg[k] <= 4'h0;
      end
    end else if (we_i && addr_i[`ACL_GLOBAL_BIT]) begin
      case (addr_i[3:0])
        `ACL_G_AUTH: auth_reg <= wdata_i[NUM_PORTS-1:0];
        `ACL_G_RSV_MCAST: rsv_mcast_reg <= wdata_i;
        default: ;
      endcase
    end else if (we_i && 32'(wp) < NUM_PORTS) begin
      case (addr_i[2:0])
        `ACL_FLD_CTRL: rule_ctrl_reg[wk] <= wdata_i[5:0];
        `ACL_FLD_DATA0: rule_d0_reg[wk] <= wdata_i;
        `ACL_FLD_DATA1: rule_d1_reg[wk] <= wdata_i;
        `ACL_FLD_ACTION: action_reg[wk] <= wdata_i;
        `ACL_FLD_PROC: begin
          sel_mask_reg[wk] <= wdata_i[15:0];
          ptr_reg[wk] <= wdata_i[`ACL_PROC_PTR_LO+3:`ACL_PROC_PTR_LO];
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // register reads, data valid one cycle after the strobe only
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= 32'h0000_0000;
      if (re_i && addr_i[`ACL_GLOBAL_BIT]) begin
        case (addr_i[3:0])
          `ACL_G_AUTH: rdata_o <= 32'(auth_reg);
          `ACL_G_RSV_MCAST: rdata_o <= rsv_mcast_reg;
          `ACL_G_FLAGS: begin
            for (int e = 0; e < 16; e++) begin
              if (32'(wp) < NUM_PORTS) begin
                rdata_o[e] <= flags_reg[wk - 32'(we_ent) + 32'(e)];
              end
            end
          end
          default: ;
        endcase
      end else if (re_i && 32'(wp) < NUM_PORTS) begin
        case (addr_i[2:0])
          `ACL_FLD_CTRL: rdata_o <= {26'h0, rule_ctrl_reg[wk]};
          `ACL_FLD_DATA0: rdata_o <= rule_d0_reg[wk];
          `ACL_FLD_DATA1: rdata_o <= rule_d1_reg[wk];
          `ACL_FLD_ACTION: rdata_o <= action_reg[wk];
          `ACL_FLD_PROC: rdata_o <= {12'h0, ptr_reg[wk], sel_mask_reg[wk]};
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // frame verdict
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_valid_o <= 1'b0;
      eapol_o <= 1'b0;
      to_host_o <= 1'b0;
      admit_o <= 1'b0;
      action_hit_o <= 1'b0;
      action_ptr_o <= 4'h0;
      action_word_o <= 32'h0000_0000;
    end else begin
      result_valid_o <= frame_valid_i;
      eapol_o <= frame_valid_i && eapol;
      to_host_o <= frame_valid_i && eapol;
      // authentication traffic must pass even while blocked
      admit_o <= frame_valid_i && !eapol && port_ok &&
                 auth_reg[frame_port_i];
      action_hit_o <= frame_valid_i && !eapol && act_vec != 16'h0000;
      action_ptr_o <= first_act;
      action_word_o <= port_ok ?
                       action_reg[idx(frame_port_i, first_act)] : 32'h0;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_eapol_in;
    frame_valid_i && eapol;
  endsequence
  property p_eapol_host;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      s_eapol_in |=> to_host_o && eapol_o && !admit_o;
  endproperty
  a_eapol_host: assert property (p_eapol_host)
    else $error("eapol frame not sent to host");
  property p_block;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      frame_valid_i && port_ok && !auth_reg[frame_port_i] |=> !admit_o;
  endproperty
  a_block: assert property (p_block)
    else $error("unauthorized port admitted a frame");
  property p_lowest;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      action_hit_o |->
        ($past(act_vec) & (16'h0001 << action_ptr_o)) != 16'h0000 &&
        ($past(act_vec) & ((16'h0001 << action_ptr_o) - 16'h0001))
        == 16'h0000;
  endproperty
  a_lowest: assert property (p_lowest)
    else $error("action is not the lowest pointer");
  property p_and;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      frame_valid_i && !eapol && port_ok &&
      sel_mask_reg[idx(frame_port_i, 4'h0)] != 16'h0000 &&
      (match_vec & sel_mask_reg[idx(frame_port_i, 4'h0)]) ==
      sel_mask_reg[idx(frame_port_i, 4'h0)]
      |=> action_hit_o &&
          action_ptr_o <= $past(ptr_reg[idx(frame_port_i, 4'h0)]);
  endproperty
  a_and: assert property (p_and)
    else $error("complete rule set gave no action");
  property p_disabled;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      frame_valid_i |-> (hit_vec & dis_vec) == 16'h0000;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled rule produced a match");
  // only plain hits may lead to an action; count hits never do
  property p_count_no_fwd;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      frame_valid_i && (hit_vec & ~cnt_mode_vec) == 16'h0000
      |=> !action_hit_o;
  endproperty
  a_count_no_fwd: assert property (p_count_no_fwd)
    else $error("count rule fed forwarding");
  sequence s_fire;
    fire != '0;
  endsequence
  property p_irq;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      s_fire |=> irq_o ##1 (irq_o || $past(clr) != '0);
  endproperty
  a_irq: assert property (p_irq)
    else $error("counter event raised no interrupt");
  property p_sticky;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      irq_o && clr == '0 |=> irq_o;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a clear");
  property p_us_tick;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      us_tick_reg |=> !us_tick_reg [*8];
  endproperty
  a_us_tick: assert property (p_us_tick)
    else $error("microsecond tick too fast");
endmodule
`default_nettype wire

//--- hdl/acl_filter_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: word addresses on the plain register port
// Notes: definitions only
`ifndef ACL_FILTER_MAP_SVH
`define ACL_FILTER_MAP_SVH
// ------------------------------------------------------------------
// address decode
// ------------------------------------------------------------------
`define ACL_GLOBAL_BIT 15
`define ACL_PORT_HI 10
`define ACL_PORT_LO 8
`define ACL_ENTRY_HI 7
`define ACL_ENTRY_LO 4
`define ACL_FLD_CTRL 3'h0
`define ACL_FLD_DATA0 3'h1
`define ACL_FLD_DATA1 3'h2
`define ACL_FLD_ACTION 3'h3
`define ACL_FLD_PROC 3'h4
`define ACL_G_AUTH 4'h0
`define ACL_G_RSV_MCAST 4'h1
`define ACL_G_FLAGS 4'h2
// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define ACL_CTRL_SRC_SEL 4
`define ACL_CTRL_EQ 5
`define ACL_ACT_TU 11
`define ACL_ACT_CA 12
`define ACL_PROC_PTR_LO 16
// ------------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------------
`define ACL_EAPOL_DA 48'h0180C2000003
`define ACL_EAPOL_OFS 16'h0003
`define ACL_RSV_MCAST_RST 32'h0180C200
`define ACL_CLK_PERIOD_NS 5
`define ACL_US_NS 1000
`define ACL_US_CYCLES (`ACL_US_NS / `ACL_CLK_PERIOD_NS)
`define ACL_MS_US 1000
`endif

//--- hdl/acl_filter_pkg.sv
// Purpose: shared types of the ingress filter
// Assumes: nothing
// Notes: layer encodings are the hardware's own
`default_nettype none
package acl_filter_pkg;
  typedef enum logic [1:0] {
    LAYER_OFF = 2'h0,
    LAYER_L2 = 2'h1,
    LAYER_L3 = 2'h2,
    LAYER_L4 = 2'h3
  } match_layer_select_t;
  typedef logic [3:0] action_rule_pointer_t;
  typedef logic [15:0] match_rule_select_mask_t;
endpackage
`default_nettype wire

//--- bench/ingress_port_model.sv
// Purpose: ingress port model feeding parsed header fields
// Assumes: one frame per call, valid for a single cycle
// Notes: destination MAC, EtherType and protocol are inverted once the valid cycle is over
`default_nettype none
module ingress_port_model (
  input wire logic ref_clk_i,
  output logic frame_valid_o,
  output logic [2:0] frame_port_o,
  output logic [47:0] dst_mac_o,
  output logic [47:0] src_mac_o,
  output logic [15:0] ether_type_o,
  output logic is_ipv4_o,
  output logic is_tcp_o,
  output logic is_udp_o,
  output logic [31:0] ip_src_o,
  output logic [31:0] ip_dst_o,
  output logic [7:0] ip_proto_o,
  output logic [15:0] l4_src_o,
  output logic [15:0] l4_dst_o,
  output logic [31:0] tcp_seq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_valid_o = 1'b0;
    {frame_port_o, dst_mac_o, src_mac_o, ether_type_o, is_ipv4_o} = '0;
    {is_tcp_o, is_udp_o, ip_src_o, ip_dst_o, ip_proto_o} = '0;
    {l4_src_o, l4_dst_o, tcp_seq_o} = '0;
  end
  // ------------------------------------------------------------------
  // one frame
  // ------------------------------------------------------------------
  task automatic send_frame(input logic [2:0] p, input logic [47:0] d,
      input logic [15:0] t, input logic v4, input logic [7:0] pr);
    @(posedge ref_clk_i);
    frame_valid_o <= 1'b1;
    frame_port_o <= p;
    dst_mac_o <= d;
    ether_type_o <= t;
    is_ipv4_o <= v4;
    ip_proto_o <= pr;
    // noise fields: no rule of the bench looks at them
    src_mac_o <= 48'({$urandom(), $urandom()});
    {is_tcp_o, is_udp_o} <= 2'($urandom());
    {ip_src_o, ip_dst_o} <= {$urandom(), $urandom()};
    {l4_src_o, l4_dst_o, tcp_seq_o} <= {$urandom(), $urandom()};
    @(posedge ref_clk_i);
    frame_valid_o <= 1'b0;
    dst_mac_o <= ~d;
    ether_type_o <= ~t;
    ip_proto_o <= ~pr;
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Purpose: self-checking bench of the ingress filter
// Assumes: 200 MHz clock, word addressed register port
// Notes: random frames on ports 1 and 2, only port 1 programmed
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] MAC_A = 48'h02AABBCCDD01;
  localparam logic [47:0] MAC_E = 48'h02EE00000004;
  localparam logic [47:0] MAC_W = 48'h02EE00000005;
  localparam logic [47:0] EAP_S = 48'h0180C2000003;
  localparam logic [47:0] EAP_P = 48'h0180C2AB0003;
  logic ref_clk, resetn, we, re, fv, v4, tcp, udp;
  logic rv, eapol, host, admit, hit, irq;
  logic [15:0] addr, et, l4s, l4d;
  logic [31:0] wdata, rdata, ips, ipd, seq, word;
  logic [2:0] port;
  logic [47:0] dmac, smac;
  logic [7:0] proto;
  logic [3:0] ptr;
  int n_mismatch = 0;
  int n_checks = 0;
  ingress_port_model pm (.ref_clk_i(ref_clk), .frame_valid_o(fv),
    .frame_port_o(port), .dst_mac_o(dmac), .src_mac_o(smac),
    .ether_type_o(et), .is_ipv4_o(v4), .is_tcp_o(tcp), .is_udp_o(udp),
    .ip_src_o(ips), .ip_dst_o(ipd), .ip_proto_o(proto), .l4_src_o(l4s),
    .l4_dst_o(l4d), .tcp_seq_o(seq));
  ingress_acl_filter dut (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata),
    .frame_valid_i(fv), .frame_port_i(port), .dst_mac_i(dmac),
    .src_mac_i(smac), .ether_type_i(et), .is_ipv4_i(v4), .is_tcp_i(tcp),
    .is_udp_i(udp), .ip_src_i(ips), .ip_dst_i(ipd), .ip_proto_i(proto),
    .l4_src_i(l4s), .l4_dst_i(l4d), .tcp_seq_i(seq), .result_valid_o(rv),
    .eapol_o(eapol), .to_host_o(host), .admit_o(admit),
    .action_hit_o(hit), .action_ptr_o(ptr), .action_word_o(word),
    .irq_o(irq));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] ta(int p, int e, int f);
    return 16'((p << 8) | (e << 4) | f);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge ref_clk);
    we <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a,
      input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    re <= 1'b1;
    @(posedge ref_clk);
    re <= 1'b0;
    #1;
    cmp(what, exp, rdata);
  endtask
  // -1 means no action expected; port 1 alone holds a list
  function automatic int exp_ptr(logic [2:0] p, logic [47:0] d,
      logic [15:0] t, logic pv4, logic [7:0] pr);
    logic mh, eh, ph;
    mh = d == MAC_A;
    eh = t == 16'h88B5;
    ph = pv4 && pr == 8'h11;
    if (p != 3'h1 || d == EAP_S || d == EAP_P) return -1;
    if (mh && eh) return 1;
    if (eh || ph) return 2;
    if (mh) return 5;
    return -1;
  endfunction
  task automatic frm(input logic [2:0] p, input logic [47:0] d,
      input logic [15:0] t, input logic pv4, input logic [7:0] pr,
      input logic ad, input logic ea, input int ep);
    pm.send_frame(p, d, t, pv4, pr);
    #1;
    cmp("result_valid", 32'h1, rv);
    cmp("eapol", ea, eapol);
    cmp("to_host", ea, host);
    cmp("admit", ad, admit);
    cmp("action_hit", ep >= 0, hit);
    if (ep >= 0) begin
      cmp("action_ptr", ep, ptr);
      cmp("action_word", 32'hA0000000 | ep, word);
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict;
  end
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    logic [47:0] d;
    logic [15:0] t;
    logic [7:0] pr;
    logic [2:0] p;
    logic b4, ea;
    {resetn, we, re, addr, wdata} = '0;
    void'($urandom(32'h5409));
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_chk("auth", 16'h8000, 32'h0);
    rd_chk("rsv_base", 16'h8001, 32'h0180C200);
    rd_chk("unmapped", ta(1, 0, 5), 32'h0);
    frm(3'h1, EAP_S, 16'h888E, 1'b0, 8'h0, 1'b0, 1'b1, -1);
    frm(3'h1, MAC_A, 16'h88B5, 1'b0, 8'h0, 1'b0, 1'b0, -1);
    $display("test reset done");
    for (int i = 0; i < 16; i++) wr(ta(1, i, 3), 32'hA0000000 | i);
    wr(ta(1, 0, 1), 32'hBBCCDD01);
    wr(ta(1, 0, 2), 32'h000002AA);
    wr(ta(1, 0, 0), 32'h00000029);
    wr(ta(1, 1, 2), 32'h88B50000);
    wr(ta(1, 1, 0), 32'h00000025);
    wr(ta(1, 2, 1), 32'h00000011);
    wr(ta(1, 2, 0), 32'h00000023);
    wr(ta(1, 3, 0), 32'h0000000C);
    wr(ta(1, 0, 4), 32'h00050001);
    wr(ta(1, 1, 4), 32'h00020002);
    wr(ta(1, 2, 4), 32'h00010003);
    wr(ta(1, 3, 4), 32'h00020004);
    wr(ta(1, 5, 4), 32'h00000008);
    wr(16'h8000, 32'h00000002);
    wr(16'h8001, 32'h0180C2AB);
    frm(3'h1, 48'h0180C2AB0004, 16'h0, 1'b0, 8'h0, 1'b1, 1'b0, -1);
    wr(ta(1, 0, 0), 32'h00000009);
    frm(3'h1, MAC_A, 16'h0, 1'b0, 8'h0, 1'b1, 1'b0, -1);
    frm(3'h1, MAC_E, 16'h0, 1'b0, 8'h0, 1'b1, 1'b0, 5);
    wr(ta(1, 0, 0), 32'h00000029);
    $display("test program done");
    for (int i = 0; i < 64; i++) begin
      p = 3'($urandom_range(2, 1));
      case ($urandom_range(3))
        0: d = MAC_A;
        1: d = EAP_S;
        2: d = EAP_P;
        default: d = 48'({$urandom(), $urandom()});
      endcase
      t = $urandom_range(1) ? 16'h88B5 : 16'($urandom());
      pr = $urandom_range(1) ? 8'h11 : 8'($urandom());
      b4 = 1'($urandom());
      ea = d == EAP_S || d == EAP_P;
      frm(p, d, t, b4, pr, !ea && p == 3'h1, ea, exp_ptr(p, d, t, b4, pr));
    end
    $display("test random done");
    wr(ta(1, 4, 1), 32'h00000004);
    wr(ta(1, 4, 2), 32'h080002EE);
    wr(ta(1, 4, 3), 32'h00001003);
    wr(ta(1, 4, 0), 32'h00000021);
    wr(ta(1, 6, 4), 32'h00000010);
    repeat (2) frm(3'h1, MAC_E, 16'h0800, 1'b0, 8'h0, 1'b1, 1'b0, -1);
    cmp("irq", 32'h0, irq);
    frm(3'h1, MAC_E, 16'h0800, 1'b0, 8'h0, 1'b1, 1'b0, -1);
    @(posedge ref_clk);
    #1;
    cmp("irq", 32'h1, irq);
    rd_chk("flags", 16'h8102, 32'h00000010);
    wr(16'h8102, 32'h00000010);
    rd_chk("flags", 16'h8102, 32'h0);
    repeat (2) frm(3'h1, MAC_E, 16'h0800, 1'b0, 8'h0, 1'b1, 1'b0, -1);
    cmp("irq", 32'h0, irq);
    $display("test event done");
    wr(ta(1, 5, 1), 32'h00000005);
    wr(ta(1, 5, 2), 32'h080002EE);
    wr(ta(1, 5, 3), 32'h00000002);
    wr(ta(1, 5, 0), 32'h00000021);
    frm(3'h1, MAC_W, 16'h0800, 1'b0, 8'h0, 1'b1, 1'b0, -1);
    repeat (150) @(posedge ref_clk);
    rd_chk("flags", 16'h8102, 32'h0);
    repeat (300) @(posedge ref_clk);
    rd_chk("flags", 16'h8102, 32'h00000020);
    cmp("irq", 32'h1, irq);
    wr(ta(1, 6, 2), 32'hFFFFFFFF);
    wr(ta(1, 7, 4), 32'h00030040);
    wr(ta(1, 6, 0), 32'h00000026);
    frm(3'h1, 48'h0, 16'h0, 1'b1, 8'h0, 1'b1, 1'b0, 3);
    frm(3'h1, 48'h0, 16'h0, 1'b0, 8'h0, 1'b1, 1'b0, -1);
    $display("test watchdog done");
    give_verdict;
  end
endmodule
`default_nettype wire
